/* dv/dpr_fab_port.sv */
// Purpose: fabric-side model driving one memory port
// Assumes: port ticks are clk_i strobes; changes land just after an edge
// Notes: idle address and data are inverted so stale values never help
`timescale 1ns/100ps
module dpr_fab_port (
  input wire logic clk_i,
  output logic tick_o,
  output logic we_o,
  output logic rd_o,
  output logic [dpr_pkg::DPR_ADDR_W-1:0] addr_o,
  output logic [dpr_pkg::DPR_DATA_W-1:0] wdata_o,
  output logic [dpr_pkg::DPR_BE_W-1:0] be_o
);
  initial begin
    {tick_o, we_o, rd_o, addr_o, wdata_o, be_o} = '0;
  end
  // tick held two edges: capture, then output update; a write lands twice, harmless
  task automatic op(input logic w, input logic [7:0] a, input logic [15:0] d,
                    input logic [1:0] be);
    @(posedge clk_i);
    tick_o <= 1'b1;
    we_o <= w;
    rd_o <= !w;
    addr_o <= a;
    wdata_o <= d;
    be_o <= be;
    repeat (2) @(posedge clk_i);
    tick_o <= 1'b0;
    rd_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
    repeat (2) @(posedge clk_i);
  endtask
endmodule // dpr_fab_port

/* dv/dpr_ram_ctrl_properties.sv */
// Purpose: port checker for the memory block
// Assumes: single clk_i domain, sync rst_i
// Notes: ctrl shadow tracks lane 0 writes only
`timescale 1ns/100ps
module dpr_ram_ctrl_chk import dpr_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [DPR_WB_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [DPR_WB_DAT_W-1:0] wb_dat_i,
  input wire logic [DPR_WB_DAT_W-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [DPR_DATA_W-1:0] rdata_a_o,
  input wire logic [DPR_DATA_W-1:0] rdata_b_o
);
  logic [5:0] shadow;
  logic req;
  logic rd_req;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rd_req = req && !wb_we_i;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shadow <= DPR_CTRL_RESET;
    end else if (req && wb_we_i && wb_adr_i == DPR_CTRL_OFS && wb_sel_i[0]) begin
      shadow <= wb_dat_i[5:0];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  chk_ack_timing: assert property (req |=> wb_ack_o) else $error("ack late");
  chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("ack without request");
  chk_rst_outs: assert property ($fell(rst_i) |-> !wb_ack_o && wb_dat_o == '0 &&
    rdata_a_o == '0 && rdata_b_o == '0) else $error("outputs not reset");
  chk_dat_hold: assert property (!rd_req |=> $stable(wb_dat_o))
    else $error("read data moved");
  chk_unmapped_rd: assert property (rd_req && wb_adr_i != DPR_CTRL_OFS &&
    wb_adr_i != DPR_STATUS_OFS |=> wb_dat_o == '0) else $error("unmapped read");
  chk_ctrl_read: assert property (rd_req && wb_adr_i == DPR_CTRL_OFS |=>
    wb_dat_o == 32'(shadow)) else $error("ctrl readback");
  chk_status_mode: assert property (rd_req && wb_adr_i == DPR_STATUS_OFS |=>
    wb_dat_o[5:4] == shadow[1:0]) else $error("status mode");
endmodule // dpr_ram_ctrl_chk

bind dpr_ram_ctrl dpr_ram_ctrl_chk i_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .rdata_a_o(rdata_a_o), .rdata_b_o(rdata_b_o));

/* dv/dpr_ram_ctrl_tb.sv */
// Purpose: self-checking bench for the memory block
// Assumes: 250 MHz clk_i, fabric ports driven by dpr_fab_port
// Notes: wishbone master waits on ack, never on a fixed count
`timescale 1ns/100ps
module dpr_ram_ctrl_tb;
  import dpr_pkg::*;
  logic clk_i, rst_i, cyc, stb, we, wb_ack_o, ce_a, ce_b, clr_a, clr_b;
  logic tk_a, tk_b, wa, wb, rb;
  logic ceo_a, ceo_b, clo_a, clo_b;
  logic [7:0] adr, aa, ab;
  logic [3:0] sel;
  logic [31:0] wdat, rd, wb_dat_o;
  logic [15:0] da, db, qa, qb;
  logic [1:0] ba, bb;
  int errors = 0;
  int checks_done = 0;
  dpr_ram_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .tick_a_i(tk_a), .tick_b_i(tk_b), .addr_a_i(aa), .addr_b_i(ab),
    .wdata_a_i(da), .wdata_b_i(db), .we_a_i(wa), .we_b_i(wb), .rden_b_i(rb), .be_a_i(ba),
    .be_b_i(bb), .ce_in_a_i(ce_a), .ce_in_b_i(ce_b), .ce_out_a_i(ceo_a), .ce_out_b_i(ceo_b),
    .clr_in_a_i(clr_a), .clr_in_b_i(clr_b), .clr_out_a_i(clo_a), .clr_out_b_i(clo_b),
    .rdata_a_o(qa), .rdata_b_o(qb));
  dpr_fab_port i_fa (.clk_i(clk_i), .tick_o(tk_a), .we_o(wa), .rd_o(), .addr_o(aa),
    .wdata_o(da), .be_o(ba));
  dpr_fab_port i_fb (.clk_i(clk_i), .tick_o(tk_b), .we_o(wb), .rd_o(rb), .addr_o(ab),
    .wdata_o(db), .be_o(bb));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, s, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) errors++;
    rd = wb_dat_o;
    {cyc, stb} <= 2'b00;
    @(posedge clk_i);
  endtask
  task automatic t_regs;
    wbx(1'b0, DPR_CTRL_OFS, '0, 4'hf);
    chk(rd, 32'h0000_0000, "ctrl reset");
    wbx(1'b1, DPR_CTRL_OFS, 32'h0000_0003, 4'h0);
    wbx(1'b0, DPR_STATUS_OFS, '0, 4'hf);
    chk(rd, 32'h0000_0000, "status reset");
    wbx(1'b1, 8'h08, 32'hffff_ffff, 4'hf);
    wbx(1'b0, 8'h08, '0, 4'hf);
    chk(rd, 32'h0000_0000, "unmapped read");
  endtask
  task automatic t_indep;
    i_fa.op(1'b1, 8'h05, 16'h1234, 2'b11);
    i_fa.op(1'b0, 8'h05, '0, 2'b11);
    chk(32'(qa), 32'h0000_1234, "a read");
    i_fb.op(1'b0, 8'h05, '0, 2'b11);
    chk(32'(qb), 32'h0000_1234, "b read");
    clr_a <= 1'b1;
    @(posedge clk_i);
    clr_a <= 1'b0;
    @(posedge clk_i);
    chk(32'(qa), 32'h0000_0000, "a clear");
    chk(32'(qb), 32'h0000_1234, "b kept");
    clr_b <= 1'b1;
    @(posedge clk_i);
    clr_b <= 1'b0;
    @(posedge clk_i);
    chk(32'(qb), 32'h0000_0000, "b clear");
    ce_a <= 1'b0;
    i_fa.op(1'b1, 8'h05, 16'hffff, 2'b11);
    ce_a <= 1'b1;
    i_fa.op(1'b0, 8'h05, '0, 2'b11);
    chk(32'(qa), 32'h0000_1234, "enable off, memory kept");
  endtask
  task automatic t_modes;
    i_fa.op(1'b1, 8'h06, 16'habcd, 2'b00);
    wbx(1'b1, DPR_CTRL_OFS, 32'h0000_0020, 4'h1);
    i_fa.op(1'b1, 8'h06, 16'h0011, 2'b01);
    i_fb.op(1'b0, 8'h06, '0, 2'b11);
    chk(32'(qb), 32'h0000_ab11, "byte enables");
    wbx(1'b1, DPR_CTRL_OFS, 32'h0000_0008, 4'h1);
    i_fa.op(1'b0, 8'h05, '0, 2'b11);
    i_fb.op(1'b1, 8'h05, 16'h5a5a, 2'b11);
    chk(32'(qa), 32'h0000_5a5a, "bypass");
    wbx(1'b1, DPR_CTRL_OFS, 32'h0000_0003, 4'h1);
    i_fa.op(1'b1, 8'h07, 16'haaaa, 2'b11);
    i_fb.op(1'b1, 8'h07, 16'hbbbb, 2'b11);
    i_fa.op(1'b0, 8'h07, '0, 2'b11);
    i_fb.op(1'b0, 8'h07, '0, 2'b11);
    chk(32'(qa), 32'h0000_aaaa, "single a");
    chk(32'(qb), 32'h0000_bbbb, "single b");
    wbx(1'b1, DPR_CTRL_OFS, 32'h0000_0002, 4'h1);
    wbx(1'b0, DPR_STATUS_OFS, '0, 4'hf);
    chk(32'(rd[5:4]), 32'h0000_0002, "status mode");
    i_fa.op(1'b1, 8'h10, 16'h0f0f, 2'b11);
    i_fb.op(1'b1, 8'h10, 16'h0000, 2'b11);
    i_fb.op(1'b0, 8'h10, '0, 2'b11);
    chk(32'(qb), 32'h0000_0f0f, "read/write split");
  endtask
  task automatic t_inout;
    wbx(1'b1, DPR_CTRL_OFS, 32'h0000_0001, 4'h1);
    i_fa.op(1'b1, 8'h20, 16'h3c3c, 2'b11);
    i_fa.op(1'b0, 8'h20, '0, 2'b11);
    chk(32'(qa), 32'h0000_aaaa, "output moved on input tick");
    i_fb.op(1'b0, 8'h21, '0, 2'b11);
    chk(32'(qa), 32'h0000_3c3c, "output tick load");
    clr_a <= 1'b1;
    @(posedge clk_i);
    clr_a <= 1'b0;
    @(posedge clk_i);
    chk(32'(qa), 32'h0000_3c3c, "input clear hit output");
    clo_a <= 1'b1;
    @(posedge clk_i);
    clo_a <= 1'b0;
    @(posedge clk_i);
    chk(32'(qa), 32'h0000_0000, "output clear");
  endtask
  task automatic report_and_stop;
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    {cyc, stb, we, adr, sel, wdat} = '0;
    {ce_a, ce_b, ceo_a, ceo_b, clr_a, clr_b, clo_a, clo_b} = 8'hf0;
    rst_i = 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_indep;
    t_modes;
    t_inout;
    report_and_stop;
  end
  initial begin
    #20000;
    errors++;
    report_and_stop;
  end
endmodule // dpr_ram_ctrl_tb

/* rtl/dpr_pkg.sv */
// Purpose: constants and types shared by the dual-port memory block
// Assumes: one clock, Wishbone classic register bus with 8-bit byte address
// Notes: widths fixed; all offsets and field positions live here
package dpr_pkg;

  localparam int DPR_DATA_W = 16;
  localparam int DPR_BE_W = 2;
  localparam int DPR_ADDR_W = 8;
  localparam int DPR_DEPTH = 256;
  localparam int DPR_SP_ADDR_W = 7;
  localparam int DPR_WB_ADR_W = 8;
  localparam int DPR_WB_DAT_W = 32;

  // register byte addresses
  localparam logic [7:0] DPR_CTRL_OFS = 8'h00;
  localparam logic [7:0] DPR_STATUS_OFS = 8'h04;

  // control register fields
  localparam int DPR_CTRL_MODE_LSB = 0;
  localparam int DPR_CTRL_SIMPLE_BIT = 2;
  localparam int DPR_CTRL_BYP_A_BIT = 3;
  localparam int DPR_CTRL_BYP_B_BIT = 4;
  localparam int DPR_CTRL_BE_USE_BIT = 5;
  localparam logic [5:0] DPR_CTRL_RESET = 6'h00;

  // status register fields
  localparam int DPR_STAT_COLL_BIT = 0;
  localparam int DPR_STAT_WRA_BIT = 1;
  localparam int DPR_STAT_WRB_BIT = 2;
  localparam int DPR_STAT_MODE_LSB = 4;

  typedef enum logic [1:0] {
    DPR_MODE_INDEP = 2'b00,
    DPR_MODE_INOUT = 2'b01,
    DPR_MODE_RDWR = 2'b10,
    DPR_MODE_SINGLE = 2'b11
  } dpr_mode_type;

endpackage

/* rtl/dpr_ram_ctrl.sv */
// Purpose: block memory with selectable clock arrangements and port control
// Assumes: port "clocks" are tick strobes from fabric logic on clk_i
// Notes: clears act at the next clk_i edge, ahead of any tick or enable
//
// Decided for this implementation: the address map and the Wishbone interface to the registers.
`timescale 1ns/100ps

// What this block does
// - independent mode: port A registers follow tick A, port B registers tick B
// - independent mode: each port has its own enable and clear, local to it
// - input/output mode works for true and simple dual-port arrangements
// - input/output mode: input tick captures data, write strobe and address
// - input/output mode: output tick (tick B) drives only the read data registers of both ports
// - input/output mode: input and output groups own separate enables and clears
// - read/write mode is simple dual-port with one write and one read tick
// - read/write mode: write tick registers data, write address, write strobe
// - read/write mode: read tick registers read data, read address, read strobe
// - read/write mode: each tick has its enable; each side its own clear
// - simple dual-port modes: all registers clear except the read strobe register
// - single-port mode splits memory into two independent 2K-bit RAMs
// - independent and true input/output modes: every port register is clearable
// - byte enables default to all set, so the write strobe alone governs
// - all input registers of a port share one tick
// - read data output register can be bypassed
module dpr_ram_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [dpr_pkg::DPR_WB_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [dpr_pkg::DPR_WB_DAT_W-1:0] wb_dat_i,
  output logic [dpr_pkg::DPR_WB_DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // port ticks
  input wire logic tick_a_i,
  input wire logic tick_b_i,
  // port A
  input wire logic [dpr_pkg::DPR_ADDR_W-1:0] addr_a_i,
  input wire logic [dpr_pkg::DPR_DATA_W-1:0] wdata_a_i,
  input wire logic we_a_i,
  input wire logic [dpr_pkg::DPR_BE_W-1:0] be_a_i,
  input wire logic ce_in_a_i,
  input wire logic ce_out_a_i,
  input wire logic clr_in_a_i,
  input wire logic clr_out_a_i,
  output logic [dpr_pkg::DPR_DATA_W-1:0] rdata_a_o,
  // port B
  input wire logic [dpr_pkg::DPR_ADDR_W-1:0] addr_b_i,
  input wire logic [dpr_pkg::DPR_DATA_W-1:0] wdata_b_i,
  input wire logic we_b_i,
  input wire logic rden_b_i,
  input wire logic [dpr_pkg::DPR_BE_W-1:0] be_b_i,
  input wire logic ce_in_b_i,
  input wire logic ce_out_b_i,
  input wire logic clr_in_b_i,
  input wire logic clr_out_b_i,
  output logic [dpr_pkg::DPR_DATA_W-1:0] rdata_b_o
);
  import dpr_pkg::*;

  logic [DPR_DATA_W-1:0] mem [DPR_DEPTH];

  logic [5:0] ctrl;
  logic coll;
  dpr_mode_type mode;
  logic simple;
  logic be_use;

  logic [DPR_ADDR_W-1:0] addr_in [2];
  logic [DPR_DATA_W-1:0] wdata_in [2];
  logic [1:0] we_in;
  logic [DPR_BE_W-1:0] be_in [2];
  logic [1:0] ce_in;
  logic [1:0] ce_out;
  logic [1:0] clr_in_raw;
  logic [1:0] clr_out_raw;
  logic [1:0] byp;

  logic [1:0] tick_in;
  logic [1:0] tick_out;
  logic [1:0] clr_in;
  logic [1:0] clr_out;
  logic [1:0] en_in;
  logic [1:0] en_out;
  logic [1:0] next_wr;
  logic [1:0] next_rd;

  logic [DPR_ADDR_W-1:0] addr_q [2];
  logic [DPR_DATA_W-1:0] wdata_q [2];
  logic [DPR_BE_W-1:0] be_q [2];
  logic [1:0] wr_go;
  logic [1:0] rd_q;
  logic rden_q;
  logic [DPR_DATA_W-1:0] dout_q [2];
  logic [DPR_DATA_W-1:0] mem_rd [2];

  logic wb_req;
  logic next_coll;
  logic [1:0] load_out;
  logic ctrl_wr;
  logic stat_wr;
  logic [DPR_WB_DAT_W-1:0] next_wb_dat;

  assign mode = dpr_mode_type'(ctrl[DPR_CTRL_MODE_LSB +: 2]);
  assign simple = (mode == DPR_MODE_RDWR) ||
                  ((mode == DPR_MODE_INOUT) && ctrl[DPR_CTRL_SIMPLE_BIT]);
  assign be_use = ctrl[DPR_CTRL_BE_USE_BIT];
  assign byp = {ctrl[DPR_CTRL_BYP_B_BIT], ctrl[DPR_CTRL_BYP_A_BIT]};

  assign addr_in[0] = addr_a_i;
  assign addr_in[1] = addr_b_i;
  assign wdata_in[0] = wdata_a_i;
  assign wdata_in[1] = wdata_b_i;
  assign we_in = {we_b_i, we_a_i};
  assign be_in[0] = be_a_i;
  assign be_in[1] = be_b_i;
  assign ce_in = {ce_in_b_i, ce_in_a_i};
  assign ce_out = {ce_out_b_i, ce_out_a_i};
  assign clr_in_raw = {clr_in_b_i, clr_in_a_i};
  assign clr_out_raw = {clr_out_b_i, clr_out_a_i};

  // which tick drives a register group; grp 0 is input, 1 is output
  function automatic logic grp_tick(dpr_mode_type m, int p, int grp, logic ta, logic tb);
    logic t;
    t = (p == 0) ? ta : tb;
    if (m == DPR_MODE_INOUT) begin
      t = (grp == 0) ? ta : tb;
    end
    return t;
  endfunction

  // pick the enable or clear that governs a group
  function automatic logic grp_ctl(dpr_mode_type m, int grp, logic in_sig, logic out_sig);
    logic s;
    s = in_sig;
    if (m == DPR_MODE_INOUT && grp == 1) begin
      s = out_sig;
    end
    return s;
  endfunction

  // single-port halves are pinned by port so the two RAMs never meet
  function automatic logic [DPR_ADDR_W-1:0] map_addr(dpr_mode_type m, int p,
                                                    logic [DPR_ADDR_W-1:0] a);
    logic [DPR_ADDR_W-1:0] r;
    r = a;
    if (m == DPR_MODE_SINGLE) begin
      r = {p[0], a[DPR_SP_ADDR_W-1:0]};
    end
    return r;
  endfunction

  // every field sits in lane 0, so a write without sel[0] is dropped
  function automatic logic lane0_write(logic req, logic we, logic [3:0] sel,
                                       logic [DPR_WB_ADR_W-1:0] adr,
                                       logic [DPR_WB_ADR_W-1:0] ofs);
    return req && we && sel[0] && (adr == ofs);
  endfunction

  always_comb begin
    for (int p = 0; p < 2; p++) begin
      tick_in[p] = grp_tick(mode, p, 0, tick_a_i, tick_b_i);
      tick_out[p] = grp_tick(mode, p, 1, tick_a_i, tick_b_i);
      clr_in[p] = grp_ctl(mode, 0, clr_in_raw[p], clr_out_raw[p]);
      clr_out[p] = grp_ctl(mode, 1, clr_in_raw[p], clr_out_raw[p]);
      en_in[p] = tick_in[p] && grp_ctl(mode, 0, ce_in[p], ce_out[p]);
      en_out[p] = tick_out[p] && grp_ctl(mode, 1, ce_in[p], ce_out[p]);
      if (simple) begin
        // port A writes only, port B reads only
        next_wr[p] = (p == 0) && we_in[p];
        next_rd[p] = (p == 1) && rden_b_i;
      end else begin
        next_wr[p] = we_in[p];
        next_rd[p] = !we_in[p];
      end
    end
  end

  // input register group: address, data, strobe and byte enables share one tick
  // address register; single-port mode pins the top bit to the port
  always_ff @(posedge clk_i) begin
    for (int p = 0; p < 2; p++) begin
      if (rst_i || clr_in[p]) begin
        addr_q[p] <= '0;
      end else if (en_in[p]) begin
        addr_q[p] <= map_addr(mode, p, addr_in[p]);
      end
    end
  end

  // write data register
  always_ff @(posedge clk_i) begin
    for (int p = 0; p < 2; p++) begin
      if (rst_i || clr_in[p]) begin
        wdata_q[p] <= '0;
      end else if (en_in[p]) begin
        wdata_q[p] <= wdata_in[p];
      end
    end
  end

  // byte enable register; unused enables read as all set
  always_ff @(posedge clk_i) begin
    for (int p = 0; p < 2; p++) begin
      if (rst_i || clr_in[p]) begin
        be_q[p] <= '0;
      end else if (en_in[p]) begin
        be_q[p] <= be_use ? be_in[p] : {DPR_BE_W{1'b1}};
      end
    end
  end

  // read flag register, taken from the combined strobe or the read strobe
  always_ff @(posedge clk_i) begin
    for (int p = 0; p < 2; p++) begin
      if (rst_i || clr_in[p]) begin
        rd_q[p] <= 1'b0;
      end else if (en_in[p]) begin
        rd_q[p] <= next_rd[p];
      end
    end
  end

  // write pulse follows the capture by one cycle
  always_ff @(posedge clk_i) begin
    for (int p = 0; p < 2; p++) begin
      if (rst_i || clr_in[p]) begin
        wr_go[p] <= 1'b0;
      end else begin
        wr_go[p] <= en_in[p] && next_wr[p];
      end
    end
  end

  // read strobe register: no clear in simple arrangements
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rden_q <= 1'b0;
    end else if (clr_in[1] && !simple) begin
      rden_q <= 1'b0;
    end else if (en_in[1]) begin
      rden_q <= rden_b_i;
    end
  end

  // memory: port B first so port A wins a same-address collision
  always_ff @(posedge clk_i) begin
    for (int p = 1; p >= 0; p--) begin
      if (wr_go[p]) begin
        for (int b = 0; b < DPR_BE_W; b++) begin
          if (be_q[p][b]) begin
            mem[addr_q[p]][b*8 +: 8] <= wdata_q[p][b*8 +: 8];
          end
        end
      end
    end
  end

  always_comb begin
    for (int p = 0; p < 2; p++) begin
      mem_rd[p] = mem[addr_q[p]];
    end
  end

  // output load: output tick and enable, a pending read, and the read strobe
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      load_out[p] = en_out[p] && rd_q[p];
    end
    if (simple && !rden_q) begin
      load_out[1] = 1'b0;
    end
  end

  // output register group
  always_ff @(posedge clk_i) begin
    for (int p = 0; p < 2; p++) begin
      if (rst_i || clr_out[p]) begin
        dout_q[p] <= '0;
      end else if (load_out[p]) begin
        dout_q[p] <= mem_rd[p];
      end
    end
  end

  // bypass trades a cycle of latency for an unregistered path
  assign rdata_a_o = byp[0] ? mem_rd[0] : dout_q[0];
  assign rdata_b_o = byp[1] ? mem_rd[1] : dout_q[1];

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign next_coll = wr_go[0] && wr_go[1] && (addr_q[0] == addr_q[1]);
  assign ctrl_wr = lane0_write(wb_req, wb_we_i, wb_sel_i, wb_adr_i, DPR_CTRL_OFS);
  assign stat_wr = lane0_write(wb_req, wb_we_i, wb_sel_i, wb_adr_i, DPR_STATUS_OFS);

  // read word built from live register state; latched only when a read is taken
  always_comb begin
    next_wb_dat = '0;
    if (wb_adr_i == DPR_CTRL_OFS) begin
      next_wb_dat[5:0] = ctrl;
    end else if (wb_adr_i == DPR_STATUS_OFS) begin
      next_wb_dat[DPR_STAT_COLL_BIT] = coll;
      next_wb_dat[DPR_STAT_WRA_BIT] = wr_go[0];
      next_wb_dat[DPR_STAT_WRB_BIT] = wr_go[1];
      next_wb_dat[DPR_STAT_MODE_LSB +: 2] = mode;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= DPR_CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl <= wb_dat_i[5:0];
    end
  end

  // set wins over a same-cycle write-one clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      coll <= 1'b0;
    end else if (next_coll) begin
      coll <= 1'b1;
    end else if (stat_wr && wb_dat_i[DPR_STAT_COLL_BIT]) begin
      coll <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (wb_req && !wb_we_i) begin
      wb_dat_o <= next_wb_dat;
    end
  end

endmodule // dpr_ram_ctrl
